// [icr_map.svh]
// Register map, field positions, reset values and timing counts of the configuration block
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define ICR_IDX_CCR 8'hf3
`define ICR_IDX_OAR_LOW 8'hf4
`define ICR_IDX_OAR_HIGH 8'hf5
`define ICR_IDX_DATA 8'hf6
`define ICR_IDX_GCA 8'hf7
`define ICR_IDX_ISR 8'hf8
`define ICR_IDX_IVR 8'hf9
`define ICR_IDX_RDAP 8'hfa
`define ICR_IDX_ECCR 8'hfe
`define ICR_IDX_CTRL 8'he0
`define ICR_IDX_DSEG 8'he1

// ============================================================
// Reset values
`define ICR_RST_ZERO 8'h00
`define ICR_RST_GCA 8'ha0
`define ICR_RST_PRIO 3'h7

// ============================================================
// Field positions
`define ICR_CCR_FAST 7
`define ICR_OARH_FREQ1 7
`define ICR_OARH_FREQ0 6
`define ICR_OARH_TEN 5
`define ICR_OARH_FREQ2 4
`define ICR_ISR_ONE 7
`define ICR_ISR_ERRP 2
`define ICR_ISR_RXP 1
`define ICR_ISR_TXP 0
`define ICR_CTRL_PE 0
`define ICR_CTRL_ITE 1
`define ICR_CTRL_DSTOP 2
`define ICR_CTRL_RXREG 3

// ============================================================
// Encodings and constants
`define ICR_ADDR_NEVER 8'h01
`define ICR_TEN_HEADER 5'h1e
`define ICR_PRIO_NONE 3'h7
`define ICR_EV_NONE 2'h0
`define ICR_EV_ERR 2'h1
`define ICR_EV_RX 2'h2
`define ICR_EV_TX 2'h3

// ============================================================
// Bus timing delay, in internal clock cycles, per clock range code
`define ICR_DLY_R0 8'h03
`define ICR_DLY_R1 8'h05
`define ICR_DLY_R2 8'h07
`define ICR_DLY_R3 8'h0c

`endif

// [icr_pkg.sv]
// Types shared by the configuration and interrupt register block
package icr_pkg;

    // Request sources in fixed order of precedence
    typedef enum logic [2:0] {
        ICR_SRC_NONE,
        ICR_SRC_ERR_STOP,
        ICR_SRC_RX_DMA,
        ICR_SRC_TX_DMA,
        ICR_SRC_ERR,
        ICR_SRC_RX,
        ICR_SRC_TX
    } icr_src_t;

endpackage

// [icr_regs.sv]
// Configuration, data, address match and interrupt registers of the two-wire bus interface
// Contract
// - Fast/standard select is software only and survives disable.
// - Nine-bit SCL divider from low seven and extended two high bits, kept on disable.
// - Seven-bit mode compares own address bits 7:1, direction bit ignored.
// - Address byte 01h is never acknowledged, own or general call.
// - Ten-bit address is own high bits 2:1 above all eight low bits.
// - Clock range field scales bus timing delays per internal clock range.
// - Clock range accepts writes only while disabled; software sets it first.
// - Ten-bit enable selects address mode, writable only while disabled.
// - Transmit starts after data write, or second edge after DMA completes.
// - Receive resumes after data read, or second edge after DMA completes.
// - General call address resets A0h, bit 0 ignored, written only while disabled.
// - Three-bit priority level; 0 highest, 7 no priority.
// - Fixed order: stop-error, rx DMA, tx DMA, error, receive, transmit.
// - Pending bits cleared by writing 0, writing 1 has no effect.
// - Error pending forced high while any error event flag stands.
// - Receive and transmit pending set on their events only with interrupts enabled.
// - Vector holds base 7:3, source code 2:1, bit 0 zero.
// - Memory-space receive DMA uses pointer bits 7:1 as register address.
// - Receive DMA extension from status register or segment register by select bit.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "icr_map.svh"

module icr_regs (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [6:0] err_flags_in,
    input wire logic err_event_in,
    input wire logic rx_byte_valid_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic tx_ready_in,
    input wire logic transmitter_in,
    input wire logic dma_done_in,
    input wire logic rx_dma_req_in,
    input wire logic tx_dma_req_in,
    input wire logic addr_check_in,
    input wire logic [7:0] addr_first_in,
    input wire logic [7:0] addr_second_in,
    output logic [8:0] scl_divider_out,
    output logic fast_standard_select_out,
    output logic [2:0] clock_range_field_out,
    output logic [7:0] timing_delay_out,
    output logic ten_bit_enable_out,
    output logic peripheral_enable_out,
    output logic addr_ack_out,
    output logic gc_match_out,
    output logic [7:0] tx_byte_out,
    output logic tx_load_out,
    output logic rx_release_out,
    output logic [2:0] priority_level_out,
    output icr_pkg::icr_src_t req_source_out,
    output logic req_active_out,
    output logic [6:0] rx_pointer_address_out,
    output logic [7:0] rx_extension_out
);
    import icr_pkg::*;

    // ============================================================
    // Reset release
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ============================================================
    // Functions
    function automatic logic [7:0] range_delay(input logic [2:0] code);
        logic [7:0] d;
        d = `ICR_DLY_R3;
        case (code[1:0])
            2'h0: d = `ICR_DLY_R0;
            2'h1: d = `ICR_DLY_R1;
            2'h2: d = `ICR_DLY_R2;
            default: d = `ICR_DLY_R3;
        endcase
        return d;
    endfunction

    function automatic logic addr7_hit(input logic [7:0] rx, input logic [7:0] ref_addr);
        return (rx[7:1] == ref_addr[7:1]) && (rx != `ICR_ADDR_NEVER);
    endfunction

    // ============================================================
    // Registers
    logic [7:0] ccr;
    logic [7:0] oar_low;
    logic [7:0] oar_high;
    logic [7:0] data_buf;
    logic [7:0] gca;
    logic [2:0] prio;
    logic errp;
    logic rxp;
    logic txp;
    logic [4:0] vec_base;
    logic [1:0] vec_src;
    logic [7:0] rdap;
    logic [1:0] eccr;
    logic [3:0] ctrl;
    logic [7:0] dseg;
    logic ack;
    logic [31:0] rdata;
    logic addr_ack;
    logic gc_match;
    logic tx_load;
    logic rx_release;
    logic dma_done_d;

    logic [7:0] next_ccr;
    logic [7:0] next_oar_low;
    logic [7:0] next_oar_high;
    logic [7:0] next_data_buf;
    logic [7:0] next_gca;
    logic [2:0] next_prio;
    logic next_errp;
    logic next_rxp;
    logic next_txp;
    logic [4:0] next_vec_base;
    logic [1:0] next_vec_src;
    logic [7:0] next_rdap;
    logic [1:0] next_eccr;
    logic [3:0] next_ctrl;
    logic [7:0] next_dseg;
    logic next_ack;
    logic [31:0] next_rdata;
    logic next_addr_ack;
    logic next_gc_match;
    logic next_tx_load;
    logic next_rx_release;

    logic [7:0] idx;
    logic req;
    logic wr;
    logic rd;
    logic pe;
    logic interrupt_enable_bit;
    logic [7:0] isr_val;
    logic [7:0] ivr_val;
    logic own_hit;
    logic gc_hit;
    icr_src_t src;

    assign idx = wb_adr_in[9:2];
    assign req = wb_cyc_in && wb_stb_in;
    assign wr = req && ack && wb_we_in && wb_sel_in[0];
    assign rd = req && ack && !wb_we_in;
    assign pe = ctrl[`ICR_CTRL_PE];
    assign interrupt_enable_bit = ctrl[`ICR_CTRL_ITE];
    assign isr_val = {1'b1, prio, 1'b0, errp, rxp, txp};
    assign ivr_val = {vec_base, vec_src, 1'b0};

    // ============================================================
    // Address recognition
    always_comb begin
        if (oar_high[`ICR_OARH_TEN]) begin
            own_hit = (addr_first_in[7:3] == `ICR_TEN_HEADER) &&
                      (addr_first_in[2:1] == oar_high[2:1]) &&
                      (addr_second_in == oar_low);
        end else begin
            own_hit = addr7_hit(addr_first_in, oar_low);
        end
        if (addr_first_in == `ICR_ADDR_NEVER) begin
            own_hit = 1'b0;
        end
        gc_hit = addr7_hit(addr_first_in, gca);
    end

    // ============================================================
    // Request precedence
    always_comb begin
        if (errp && ctrl[`ICR_CTRL_DSTOP]) begin
            src = ICR_SRC_ERR_STOP;
        end else if (rx_dma_req_in) begin
            src = ICR_SRC_RX_DMA;
        end else if (tx_dma_req_in) begin
            src = ICR_SRC_TX_DMA;
        end else if (errp) begin
            src = ICR_SRC_ERR;
        end else if (rxp) begin
            src = ICR_SRC_RX;
        end else if (txp) begin
            src = ICR_SRC_TX;
        end else begin
            src = ICR_SRC_NONE;
        end
    end

    // ============================================================
    // Next values
    always_comb begin
        next_ccr = ccr;
        next_oar_low = oar_low;
        next_oar_high = oar_high;
        next_data_buf = data_buf;
        next_gca = gca;
        next_prio = prio;
        next_errp = errp;
        next_rxp = rxp;
        next_txp = txp;
        next_vec_base = vec_base;
        next_rdap = rdap;
        next_eccr = eccr;
        next_ctrl = ctrl;
        next_dseg = dseg;
        next_ack = req && !ack;
        next_rdata = 32'h0000_0000;
        next_addr_ack = 1'b0;
        next_gc_match = 1'b0;
        next_tx_load = 1'b0;
        next_rx_release = 1'b0;

        // Bus read data, unmapped reads zero
        if (req && !ack) begin
            case (idx)
                `ICR_IDX_CCR: next_rdata[7:0] = ccr;
                `ICR_IDX_OAR_LOW: next_rdata[7:0] = oar_low;
                `ICR_IDX_OAR_HIGH: next_rdata[7:0] = oar_high;
                `ICR_IDX_DATA: next_rdata[7:0] = data_buf;
                `ICR_IDX_GCA: next_rdata[7:0] = gca;
                `ICR_IDX_ISR: next_rdata[7:0] = isr_val;
                `ICR_IDX_IVR: next_rdata[7:0] = ivr_val;
                `ICR_IDX_RDAP: next_rdata[7:0] = rdap;
                `ICR_IDX_ECCR: next_rdata[1:0] = eccr;
                `ICR_IDX_CTRL: next_rdata[3:0] = ctrl;
                `ICR_IDX_DSEG: next_rdata[7:0] = dseg;
                default: next_rdata = 32'h0000_0000;
            endcase
        end

        // Bus writes
        if (wr) begin
            case (idx)
                `ICR_IDX_CCR: next_ccr = wb_dat_in[7:0];
                `ICR_IDX_OAR_LOW: next_oar_low = wb_dat_in[7:0];
                `ICR_IDX_OAR_HIGH: begin
                    next_oar_high[2:1] = wb_dat_in[2:1];
                    if (!pe) begin
                        next_oar_high[`ICR_OARH_FREQ1] = wb_dat_in[`ICR_OARH_FREQ1];
                        next_oar_high[`ICR_OARH_FREQ0] = wb_dat_in[`ICR_OARH_FREQ0];
                        next_oar_high[`ICR_OARH_FREQ2] = wb_dat_in[`ICR_OARH_FREQ2];
                        next_oar_high[`ICR_OARH_TEN] = wb_dat_in[`ICR_OARH_TEN];
                    end
                end
                `ICR_IDX_DATA: begin
                    next_data_buf = wb_dat_in[7:0];
                    next_tx_load = transmitter_in;
                end
                `ICR_IDX_GCA: begin
                    if (!pe) begin
                        next_gca = wb_dat_in[7:0];
                    end
                end
                `ICR_IDX_ISR: begin
                    next_prio = wb_dat_in[6:4];
                    next_errp = errp && wb_dat_in[`ICR_ISR_ERRP];
                    next_rxp = rxp && wb_dat_in[`ICR_ISR_RXP];
                    next_txp = txp && wb_dat_in[`ICR_ISR_TXP];
                end
                `ICR_IDX_IVR: next_vec_base = wb_dat_in[7:3];
                `ICR_IDX_RDAP: next_rdap = wb_dat_in[7:0];
                `ICR_IDX_ECCR: next_eccr = wb_dat_in[1:0];
                `ICR_IDX_CTRL: next_ctrl = wb_dat_in[3:0];
                `ICR_IDX_DSEG: next_dseg = wb_dat_in[7:0];
                default: next_ctrl = ctrl;
            endcase
        end

        // Data register pacing
        if (rd && (idx == `ICR_IDX_DATA) && !transmitter_in) begin
            next_rx_release = 1'b1;
        end
        if (dma_done_d) begin
            next_tx_load = transmitter_in;
            next_rx_release = !transmitter_in;
        end
        if (rx_byte_valid_in) begin
            next_data_buf = rx_byte_in;
        end

        // Pending bits: set wins over clear
        if ((err_event_in && interrupt_enable_bit) || (|err_flags_in)) begin
            next_errp = 1'b1;
        end
        if (rx_byte_valid_in && interrupt_enable_bit) begin
            next_rxp = 1'b1;
        end
        if (tx_ready_in && interrupt_enable_bit) begin
            next_txp = 1'b1;
        end

        // Address answer
        if (addr_check_in && pe) begin
            next_addr_ack = own_hit || gc_hit;
            next_gc_match = gc_hit && !own_hit;
        end
    end

    // Vector source code from the highest-ranked request; held while a DMA request or no request ranks first
    always_comb begin
        case (src)
            ICR_SRC_ERR_STOP: next_vec_src = `ICR_EV_ERR;
            ICR_SRC_ERR: next_vec_src = `ICR_EV_ERR;
            ICR_SRC_RX: next_vec_src = `ICR_EV_RX;
            ICR_SRC_TX: next_vec_src = `ICR_EV_TX;
            default: next_vec_src = vec_src;
        endcase
    end

    // ============================================================
    // State registers
    always_ff @(posedge clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            ccr <= `ICR_RST_ZERO;
            oar_low <= `ICR_RST_ZERO;
            oar_high <= `ICR_RST_ZERO;
            data_buf <= `ICR_RST_ZERO;
            gca <= `ICR_RST_GCA;
            prio <= `ICR_RST_PRIO;
            errp <= 1'b0;
            rxp <= 1'b0;
            txp <= 1'b0;
            vec_base <= 5'h00;
            vec_src <= `ICR_EV_NONE;
            rdap <= `ICR_RST_ZERO;
            eccr <= 2'h0;
            ctrl <= 4'h0;
            dseg <= `ICR_RST_ZERO;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            addr_ack <= 1'b0;
            gc_match <= 1'b0;
            tx_load <= 1'b0;
            rx_release <= 1'b0;
            dma_done_d <= 1'b0;
        end else begin
            ccr <= next_ccr;
            oar_low <= next_oar_low;
            oar_high <= next_oar_high;
            data_buf <= next_data_buf;
            gca <= next_gca;
            prio <= next_prio;
            errp <= next_errp;
            rxp <= next_rxp;
            txp <= next_txp;
            vec_base <= next_vec_base;
            vec_src <= next_vec_src;
            rdap <= next_rdap;
            eccr <= next_eccr;
            ctrl <= next_ctrl;
            dseg <= next_dseg;
            ack <= next_ack;
            rdata <= next_rdata;
            addr_ack <= next_addr_ack;
            gc_match <= next_gc_match;
            tx_load <= next_tx_load;
            rx_release <= next_rx_release;
            dma_done_d <= dma_done_in;
        end
    end

    // ============================================================
    // Outputs
    assign wb_ack_out = ack;
    assign wb_dat_out = rdata;
    assign scl_divider_out = {eccr, ccr[6:0]};
    assign fast_standard_select_out = ccr[`ICR_CCR_FAST];
    assign clock_range_field_out = {oar_high[`ICR_OARH_FREQ2], oar_high[`ICR_OARH_FREQ1],
                                    oar_high[`ICR_OARH_FREQ0]};
    assign timing_delay_out = range_delay(clock_range_field_out);
    assign ten_bit_enable_out = oar_high[`ICR_OARH_TEN];
    assign peripheral_enable_out = pe;
    assign addr_ack_out = addr_ack;
    assign gc_match_out = gc_match;
    assign tx_byte_out = data_buf;
    assign tx_load_out = tx_load;
    assign rx_release_out = rx_release;
    assign priority_level_out = prio;
    assign req_source_out = src;
    assign req_active_out = (src != ICR_SRC_NONE) && (prio != `ICR_PRIO_NONE);
    assign rx_pointer_address_out = ctrl[`ICR_CTRL_RXREG] ? 7'h00 : rdap[7:1];
    assign rx_extension_out = rdap[0] ? dseg : isr_val;

endmodule

// [icr_regs_assertions.sv]
// Concurrent checks on the ports of the register block
`timescale 1ns/1ps

module icr_regs_chk (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic wb_ack_out,
    input wire logic rx_byte_valid_in,
    input wire logic transmitter_in,
    input wire logic dma_done_in,
    input wire logic rx_dma_req_in,
    input wire logic addr_check_in,
    input wire logic [7:0] addr_first_in,
    input wire logic [8:0] scl_divider_out,
    input wire logic fast_standard_select_out,
    input wire logic [2:0] clock_range_field_out,
    input wire logic [7:0] timing_delay_out,
    input wire logic ten_bit_enable_out,
    input wire logic peripheral_enable_out,
    input wire logic addr_ack_out,
    input wire logic gc_match_out,
    input wire logic [7:0] tx_byte_out,
    input wire logic tx_load_out,
    input wire logic rx_release_out,
    input wire logic [2:0] priority_level_out,
    input wire icr_pkg::icr_src_t req_source_out,
    input wire logic req_active_out
);
    import icr_pkg::*;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    // ============================================================
    // Helpers
    function automatic logic [7:0] exp_dly(input logic [1:0] c);
        exp_dly = (c == 2'h0) ? 8'h03 : (c == 2'h1) ? 8'h05 : (c == 2'h2) ? 8'h07 : 8'h0c;
    endfunction

    sequence s_data_acc(logic w);
        wb_cyc_in && wb_stb_in && wb_ack_out && (wb_we_in == w) && (wb_adr_in[9:2] == 8'hf6);
    endsequence

    // ============================================================
    // Properties
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_tx_on_write: assert property (
        s_data_acc(1'b1) ##0 (wb_sel_in[0] && transmitter_in && peripheral_enable_out && !rx_byte_valid_in)
        |=> tx_load_out && (tx_byte_out == $past(wb_dat_in[7:0])))
        else $error("data write did not start transmission");
    a_rx_on_read: assert property (
        s_data_acc(1'b0) ##0 (!transmitter_in && peripheral_enable_out) |=> rx_release_out)
        else $error("data read did not release receiver");
    a_tx_after_dma: assert property (
        dma_done_in && transmitter_in && peripheral_enable_out |-> ##2 tx_load_out)
        else $error("no transmit after dma done");
    a_addr_never_one: assert property (
        addr_check_in && (addr_first_in == 8'h01) |=> !addr_ack_out && !gc_match_out)
        else $error("address 01h acknowledged");
    a_no_ack_off: assert property (
        addr_check_in && !peripheral_enable_out |=> !(addr_ack_out || gc_match_out))
        else $error("address acknowledged while disabled");
    a_delay_table: assert property (
        $stable(clock_range_field_out) |-> timing_delay_out == exp_dly(clock_range_field_out[1:0]))
        else $error("timing delay does not follow clock range");
    a_cfg_locked: assert property (
        peripheral_enable_out |=> $stable(clock_range_field_out) && $stable(ten_bit_enable_out))
        else $error("locked field changed while enabled");
    a_kept_on_off: assert property (
        $fell(peripheral_enable_out) |-> $stable(scl_divider_out) && $stable(fast_standard_select_out))
        else $error("divider lost on disable");
    a_prio_none: assert property (
        priority_level_out == 3'h7 |-> !req_active_out)
        else $error("request active at priority 7");
    a_dma_order: assert property (
        req_active_out && rx_dma_req_in |-> req_source_out inside {ICR_SRC_ERR_STOP, ICR_SRC_RX_DMA})
        else $error("receive dma not ranked");
endmodule

// [icr_core_model.sv]
// Behavioural model of the transfer core feeding events and address bytes
`timescale 1ns/1ps

module icr_core_model (
    input wire logic clk_in,
    input wire logic addr_ack_in,
    input wire logic gc_match_in,
    output logic [6:0] err_flags_out,
    output logic err_event_out,
    output logic rx_byte_valid_out,
    output logic [7:0] rx_byte_out,
    output logic tx_ready_out,
    output logic transmitter_out,
    output logic dma_done_out,
    output logic rx_dma_req_out,
    output logic tx_dma_req_out,
    output logic addr_check_out,
    output logic [7:0] addr_first_out,
    output logic [7:0] addr_second_out
);
    // ============================================================
    // Idle levels
    initial begin
        err_flags_out = 7'h00;
        {err_event_out, rx_byte_valid_out, tx_ready_out, dma_done_out} = 4'h0;
        {transmitter_out, rx_dma_req_out, tx_dma_req_out, addr_check_out} = 4'h0;
        {rx_byte_out, addr_first_out, addr_second_out} = 24'h00_0000;
    end

    // ============================================================
    // One-cycle pulse: mask is dma done, tx ready, rx valid, error event
    task automatic ev(input logic [3:0] m, input logic [7:0] b);
        @(posedge clk_in);
        {dma_done_out, tx_ready_out, rx_byte_valid_out, err_event_out} <= m;
        rx_byte_out <= b;
        @(posedge clk_in);
        {dma_done_out, tx_ready_out, rx_byte_valid_out, err_event_out} <= 4'h0;
        rx_byte_out <= ~b;
    endtask

    // Address bytes offered for one cycle, answer taken in the next
    task automatic probe(input logic [7:0] a, input logic [7:0] b, output logic k, output logic g);
        @(posedge clk_in);
        addr_check_out <= 1'b1;
        addr_first_out <= a;
        addr_second_out <= b;
        @(posedge clk_in);
        addr_check_out <= 1'b0;
        addr_first_out <= ~a;
        addr_second_out <= ~b;
        @(negedge clk_in);
        k = addr_ack_in;
        g = gc_match_in;
    endtask
endmodule

// [tb.sv]
// Self-checking bench for the configuration and interrupt register block
`timescale 1ns/1ps

module tb;
    import icr_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, ka, kg;
    logic [9:0] wb_adr_in;
    logic [3:0] wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out;
    logic [6:0] err_flags_in, rx_pointer_address_out;
    logic err_event_in, rx_byte_valid_in, tx_ready_in, transmitter_in, dma_done_in, rx_dma_req_in, tx_dma_req_in;
    logic addr_check_in, fast_standard_select_out, ten_bit_enable_out, peripheral_enable_out, addr_ack_out;
    logic gc_match_out, tx_load_out, rx_release_out, req_active_out;
    logic [7:0] rx_byte_in, addr_first_in, addr_second_in, timing_delay_out, tx_byte_out, rx_extension_out, q;
    logic [8:0] scl_divider_out;
    logic [2:0] clock_range_field_out, priority_level_out;
    icr_src_t req_source_out;
    int bad_count = 0;
    int checked = 0;
    int i;
    logic [7:0] rix [9] = '{8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'h10};
    logic [7:0] rrv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, 8'hf0, 8'h00, 8'h00, 8'h00};
    logic [7:0] dly [4] = '{8'h03, 8'h05, 8'h07, 8'h0c};

    icr_regs u_dut (.*);
    icr_core_model u_core (
        .clk_in(clk_in), .addr_ack_in(addr_ack_out), .gc_match_in(gc_match_out),
        .err_flags_out(err_flags_in), .err_event_out(err_event_in), .rx_byte_valid_out(rx_byte_valid_in),
        .rx_byte_out(rx_byte_in), .tx_ready_out(tx_ready_in), .transmitter_out(transmitter_in),
        .dma_done_out(dma_done_in), .rx_dma_req_out(rx_dma_req_in), .tx_dma_req_out(tx_dma_req_in),
        .addr_check_out(addr_check_in), .addr_first_out(addr_first_in), .addr_second_out(addr_second_in)
    );

    always #5 clk_in = ~clk_in;

    // ============================================================
    // Tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= {a, 2'b00};
        wb_dat_in <= {24'h00_0000, d};
        do @(posedge clk_in);
        while (wb_ack_out !== 1'b1);
        r = wb_dat_out[7:0];
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, q);
        chk(q, e);
    endtask

    task automatic pr(input logic [7:0] a, input logic [7:0] b, input logic ea, input logic eg);
        u_core.probe(a, b, ka, kg);
        chk(ka, ea);
        chk(kg, eg);
    endtask

    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        bad_count++;
        end_sim;
    end

    // ============================================================
    // Scenarios
    initial begin
        resetn_in = 1'b0;
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = 45'h0;
        wb_sel_in = 4'h1;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        for (i = 0; i < 9; i++) rc(rix[i], rrv[i]);
        chk(priority_level_out, 3'h7);
        for (i = 0; i < 4; i++) begin
            wr(8'hf5, {i[1:0], 6'h00});
            @(negedge clk_in);
            chk(clock_range_field_out, i);
            chk(timing_delay_out, dly[i]);
        end
        wr(8'hf3, 8'h85);
        wr(8'hfe, 8'h02);
        wr(8'hf4, 8'h5a);
        wr(8'hf7, 8'h00);
        wr(8'he0, 8'h01);
        wr(8'hf5, 8'h20);
        wr(8'hf7, 8'h44);
        rc(8'hf5, 8'hc0);
        rc(8'hf7, 8'h00);
        pr(8'h5b, 8'h00, 1'b1, 1'b0);
        pr(8'h01, 8'h00, 1'b0, 1'b0);
        pr(8'h00, 8'h00, 1'b1, 1'b1);
        pr(8'h5c, 8'h00, 1'b0, 1'b0);
        wr(8'he0, 8'h00);
        pr(8'h5b, 8'h00, 1'b0, 1'b0);
        chk(scl_divider_out, 9'h105);
        chk(fast_standard_select_out, 1'b1);
        wr(8'hf5, 8'he4);
        wr(8'he0, 8'h01);
        chk(ten_bit_enable_out, 1'b1);
        pr(8'hf4, 8'h5a, 1'b1, 1'b0);
        pr(8'hf2, 8'h5a, 1'b0, 1'b0);
        pr(8'hf4, 8'h5b, 1'b0, 1'b0);
        u_core.transmitter_out <= 1'b1;
        wr(8'hf6, 8'h3c);
        @(negedge clk_in);
        chk(tx_byte_out, 8'h3c);
        u_core.ev(4'b1000, 8'h00);
        u_core.ev(4'b0100, 8'h00);
        rc(8'hf8, 8'hf0);
        u_core.transmitter_out <= 1'b0;
        wr(8'hf9, 8'ha8);
        wr(8'hf8, 8'hb0);
        wr(8'he0, 8'h03);
        u_core.ev(4'b0010, 8'h96);
        rc(8'hf6, 8'h96);
        rc(8'hf8, 8'hb2);
        rc(8'hf9, 8'hac);
        chk(req_source_out, ICR_SRC_RX);
        wr(8'hf8, 8'hb1);
        rc(8'hf8, 8'hb0);
        u_core.ev(4'b0100, 8'h00);
        rc(8'hf8, 8'hb1);
        rc(8'hf9, 8'hae);
        u_core.err_flags_out <= 7'h04;
        wr(8'hf8, 8'hb0);
        rc(8'hf8, 8'hb4);
        chk(req_source_out, ICR_SRC_ERR);
        u_core.rx_dma_req_out <= 1'b1;
        u_core.tx_dma_req_out <= 1'b1;
        @(negedge clk_in);
        chk(req_source_out, ICR_SRC_RX_DMA);
        u_core.rx_dma_req_out <= 1'b0;
        @(negedge clk_in);
        chk(req_source_out, ICR_SRC_TX_DMA);
        wr(8'he0, 8'h07);
        @(negedge clk_in);
        chk(req_source_out, ICR_SRC_ERR_STOP);
        wr(8'hf8, 8'hf0);
        @(negedge clk_in);
        chk(req_active_out, 1'b0);
        u_core.err_flags_out <= 7'h00;
        u_core.tx_dma_req_out <= 1'b0;
        wr(8'hf8, 8'hb0);
        u_core.ev(4'b0001, 8'h00);
        rc(8'hf8, 8'hb4);
        wr(8'hf8, 8'hb0);
        wr(8'he1, 8'h3c);
        wr(8'hfa, 8'h57);
        @(negedge clk_in);
        chk(rx_pointer_address_out, 7'h2b);
        chk(rx_extension_out, 8'h3c);
        wr(8'hfa, 8'h56);
        @(negedge clk_in);
        chk(rx_extension_out, 8'hb0);
        wr(8'he0, 8'h0f);
        @(negedge clk_in);
        chk(rx_pointer_address_out, 7'h00);
        end_sim;
    end
endmodule

bind icr_regs icr_regs_chk u_chk (.*);
